// file: hw/rtc_alarm_and_control.sv
`timescale 1ns/1ns
`include "rtc_ctrl_consts.svh"
module rtc_alarm_and_control
  import rtc_ctrl_pkg::*;
#(
  parameter int PRESCALE_TICKS = `PRESCALE_TICKS
) (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [15:0] comp_value,
  input  wire logic        alarm_irq_enable,
  output logic [7:0]       reg_rdata,
  output logic             alarm_event,
  output logic             running
);
  // ----------------------------------------
  // conversion helpers
  // ----------------------------------------
  function automatic logic [7:0] bin2bcd(input logic [6:0] v);
    bin2bcd = {4'(v / 7'h0A), 4'(v % 7'h0A)};
  endfunction : bin2bcd

  function automatic logic [6:0] bcd2bin(input logic [7:0] b);
    bcd2bin = 7'(7'(b[7:4]) * 7'h0A + 7'(b[3:0]));
  endfunction : bcd2bin

  // hour as seen on the bus in the current format
  function automatic logic [7:0] hour_out(input logic [6:0] h,
                                          input logic       m12);
    logic [6:0] h12;
    logic [7:0] b12;
    logic [7:0] b24;
    h12 = (h == 7'h00) ? `HOURS_HALF :
          (h > `HOURS_HALF) ? 7'(h - `HOURS_HALF) : h;
    b12 = bin2bcd(h12);
    b24 = bin2bcd(h);
    if (m12) begin
      hour_out = {h >= `HOURS_HALF, 1'b0, b12[5:0]};
    end else begin
      hour_out = {2'h0, b24[5:0]};
    end
  endfunction : hour_out

  // bus hour byte back to 0..23
  function automatic logic [6:0] hour_in(input logic [7:0] b,
                                         input logic       m12);
    logic [6:0] h;
    h = bcd2bin({2'h0, b[5:0]});
    if (m12) begin
      hour_in = 7'(((h == `HOURS_HALF) ? 7'h00 : h) +
                   (b[`PM_BIT] ? `HOURS_HALF : 7'h00));
    end else begin
      hour_in = h;
    end
  endfunction : hour_in

  function automatic logic [6:0] days_in(input logic [6:0] m,
                                         input logic [6:0] y);
    case (m)
      7'h02: days_in = (y[1:0] == 2'h0) ? 7'h1D : 7'h1C;
      7'h04, 7'h06, 7'h09, 7'h0B: days_in = 7'h1E;
      default: days_in = 7'h1F;
    endcase
  endfunction : days_in

  // ----------------------------------------
  // state and decode
  // ----------------------------------------
  main_state_type  st_reg;
  main_state_type  st_next;
  logic            tick32;
  logic [6:0][6:0] cnt_val;
  logic [6:0][6:0] high;
  logic [6:0][6:0] ld_val;
  logic [6:0]      inc;
  logic [6:0]      carry;
  logic [6:0]      ld;
  logic            ctrl_wr;
  logic            time_acc;
  logic            presc_last;
  logic            sec_tick;
  logic            hour_due;
  logic            rnd_go;
  logic            rnd_bump;
  logic            date_match;
  logic [6:0][6:0] rd_src;
  logic [7:0]      rd_val;

  assign ctrl_wr  = reg_wr && (reg_addr == `OFS_CTRL);
  assign time_acc = reg_addr <= `OFS_WEEKS;

  tick_divider u_div (
    .clk  (clk),
    .nrst (nrst),
    .tick (tick32)
  );

  // seconds advance only after the resynced run bit
  assign presc_last = st_reg.presc == 16'(PRESCALE_TICKS - 1);
  assign sec_tick   = tick32 && st_reg.run_sync && presc_last;
  assign hour_due   = (cnt_val[`FLD_SEC] == `MAX_SEC) &&
                      (cnt_val[`FLD_MIN] == `MAX_SEC);

  // rounding waits for a cycle without a second tick
  assign rnd_go   = (st_reg.rnd == RND_BUSY) && !sec_tick;
  assign rnd_bump = rnd_go && (cnt_val[`FLD_SEC] >= `ROUND_HALF);

  // ----------------------------------------
  // calendar counters
  // ----------------------------------------
  assign high[`FLD_SEC]   = `MAX_SEC;
  assign high[`FLD_MIN]   = `MAX_SEC;
  assign high[`FLD_HOUR]  = `MAX_HOUR;
  assign high[`FLD_DAY]   = days_in(cnt_val[`FLD_MONTH],
                                    cnt_val[`FLD_YEAR]);
  assign high[`FLD_MONTH] = `MAX_MONTH;
  assign high[`FLD_YEAR]  = `MAX_YEAR;
  assign high[`FLD_WEEK]  = `MAX_WEEK;

  // carry chain, weekday steps with the day
  assign inc[`FLD_SEC]   = sec_tick;
  assign inc[`FLD_MIN]   = carry[`FLD_SEC] || rnd_bump;
  assign inc[`FLD_HOUR]  = carry[`FLD_MIN];
  assign inc[`FLD_DAY]   = carry[`FLD_HOUR];
  assign inc[`FLD_MONTH] = carry[`FLD_DAY];
  assign inc[`FLD_YEAR]  = carry[`FLD_MONTH];
  assign inc[`FLD_WEEK]  = carry[`FLD_HOUR];

  // bus writes to time fields, hour in the current format
  always_comb begin
    for (int i = 0; i < `NUM_FIELDS; i++) begin
      ld[i] = reg_wr && (reg_addr == 8'(i));
      ld_val[i] = bcd2bin(reg_wdata);
    end
    ld_val[`FLD_HOUR] = hour_in(reg_wdata,
                                st_reg.ctrl.hour_12_mode);
    ld[`FLD_SEC] = ld[`FLD_SEC] || rnd_go;
    if (rnd_go) begin
      ld_val[`FLD_SEC] = 7'h00;
    end
  end

  for (genvar i = 0; i < `NUM_FIELDS; i++) begin : g_cnt
    wrap_counter #(
      .LOW ((i == `FLD_DAY || i == `FLD_MONTH) ? 7'h01 : 7'h00)
    ) u_cnt (
      .clk      (clk),
      .nrst     (nrst),
      .inc      (inc[i]),
      .load     (ld[i]),
      .load_val (ld_val[i]),
      .high     (high[i]),
      .value    (cnt_val[i]),
      .carry    (carry[i])
    );
  end

  // ----------------------------------------
  // read path
  // ----------------------------------------
  assign date_match =
    (bin2bcd(cnt_val[`FLD_DAY]) == st_reg.al_day) &&
    (bin2bcd(cnt_val[`FLD_MONTH]) == st_reg.al_month) &&
    (bin2bcd(cnt_val[`FLD_YEAR]) == st_reg.al_year);

  assign rd_src = st_reg.ctrl.read_source_select ?
                  st_reg.shadow : cnt_val;

  // read value mux, unmapped offsets read zero
  always_comb begin
    rd_val = 8'h00;
    if (time_acc) begin
      rd_val = bin2bcd(rd_src[reg_addr[2:0]]);
      if (reg_addr == `OFS_HOURS) begin
        rd_val = hour_out(rd_src[`FLD_HOUR],
                          st_reg.ctrl.hour_12_mode);
      end
    end else begin
      case (reg_addr)
        `OFS_ALARM_DAY:   rd_val = st_reg.al_day;
        `OFS_ALARM_MONTH: rd_val = st_reg.al_month;
        `OFS_ALARM_YEAR:  rd_val = st_reg.al_year;
        `OFS_CTRL: begin
          rd_val = st_reg.ctrl;
          rd_val[1] = st_reg.round_seen;
        end
        default: rd_val = 8'h00;
      endcase
    end
  end

  // ----------------------------------------
  // register and control next state
  // ----------------------------------------
  always_comb begin
    st_next = st_reg;
    st_next.alarm_evt = st_reg.day_rolled && date_match &&
                        alarm_irq_enable;
    st_next.day_rolled = inc[`FLD_DAY];
    if (reg_rd) begin
      st_next.rdata = rd_val;
      if (reg_addr == `OFS_CTRL) begin
        st_next.round_seen = st_reg.ctrl.round_request;
      end
    end
    if (reg_wr) begin
      case (reg_addr)
        `OFS_ALARM_DAY:
          st_next.al_day = reg_wdata & `ALARM_DAY_MASK;
        `OFS_ALARM_MONTH:
          st_next.al_month = reg_wdata & `ALARM_MONTH_MASK;
        `OFS_ALARM_YEAR:
          st_next.al_year = reg_wdata;
        default: st_next.al_year = st_reg.al_year;
      endcase
    end
    // rounding finished, a new set in the same cycle wins
    unique case (st_reg.rnd)
      RND_IDLE: begin
        if (st_reg.ctrl.round_request) begin
          st_next.rnd = RND_BUSY;
        end
      end
      RND_BUSY: begin
        if (rnd_go) begin
          st_next.rnd = RND_IDLE;
          st_next.ctrl.round_request = 1'b0;
        end
      end
      default: begin
        st_next.rnd = RND_IDLE;
      end
    endcase
    // a written 0 never clears a pending round request
    if (ctrl_wr) begin
      st_next.ctrl = {reg_wdata[7:2],
                      reg_wdata[1] || st_next.ctrl.round_request,
                      reg_wdata[0]};
      if (reg_wdata[6] && !st_reg.ctrl.snapshot_request) begin
        st_next.shadow = cnt_val;
      end
    end
    // prescaler with compensation on its terminal count
    if (tick32) begin
      st_next.run_sync = st_reg.ctrl.run;
      if (st_reg.run_sync) begin
        if (!presc_last) begin
          st_next.presc = st_reg.presc + 16'h0001;
        end else if (st_reg.ctrl.test_mode ||
                     (st_reg.ctrl.auto_comp && hour_due)) begin
          st_next.presc = comp_value;
        end else begin
          st_next.presc = 16'h0000;
        end
      end
    end
    if (ctrl_wr && reg_wdata[5]) begin
      st_next.presc = comp_value;
    end
  end

  // full reset only
  always_ff @(posedge clk) begin
    if (!nrst) begin
      st_reg          <= '0;
      st_reg.ctrl     <= `CTRL_RST;
      st_reg.al_day   <= `ALARM_DAY_RST;
      st_reg.al_month <= `ALARM_MONTH_RST;
      st_reg.al_year  <= `ALARM_YEAR_RST;
      st_reg.rnd      <= RND_IDLE;
    end else begin
      st_reg <= st_next;
    end
  end

  assign reg_rdata   = st_reg.rdata;
  assign alarm_event = st_reg.alarm_evt;
  assign running     = st_reg.run_sync;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  property p_reset_vals;
    @(posedge clk) !nrst |=> st_reg.al_day == 8'h01 &&
      st_reg.al_month == 8'h01 && st_reg.al_year == 8'h00 &&
      st_reg.ctrl == 8'h00 && !running;
  endproperty
  a_reset_vals: assert property (p_reset_vals)
    else $error("register reset values wrong");

  property p_resv_zero;
    @(posedge clk) disable iff (!nrst)
      st_reg.al_day[7:6] == 2'h0 && st_reg.al_month[7:5] == 3'h0;
  endproperty
  a_resv_zero: assert property (p_resv_zero)
    else $error("reserved alarm bits not zero");

  property p_year_wr;
    @(posedge clk) disable iff (!nrst)
      reg_wr && reg_addr == 8'h0D |=> st_reg.al_year == $past(reg_wdata);
  endproperty
  a_year_wr: assert property (p_year_wr)
    else $error("alarm year write lost");

  property p_snapshot;
    @(posedge clk) disable iff (!nrst)
      ctrl_wr && reg_wdata[6] && !st_reg.ctrl.snapshot_request |=>
      st_reg.shadow == $past(cnt_val);
  endproperty
  a_snapshot: assert property (p_snapshot)
    else $error("snapshot did not copy counters");

  property p_no_resnap;
    @(posedge clk) disable iff (!nrst)
      ctrl_wr && st_reg.ctrl.snapshot_request |=> $stable(st_reg.shadow);
  endproperty
  a_no_resnap: assert property (p_no_resnap)
    else $error("shadow updated without fresh request");

  property p_load;
    @(posedge clk) disable iff (!nrst)
      ctrl_wr && reg_wdata[5] |=> st_reg.presc == $past(comp_value);
  endproperty
  a_load: assert property (p_load)
    else $error("prescaler not loaded");

  property p_round_done;
    @(posedge clk) disable iff (!nrst)
      $rose(st_reg.ctrl.round_request) && !reg_wr
      |-> ##[1:4] !st_reg.ctrl.round_request;
  endproperty
  a_round_done: assert property (p_round_done)
    else $error("round bit never cleared");

  property p_frozen;
    @(posedge clk) disable iff (!nrst)
      !st_reg.run_sync && !reg_wr && st_reg.rnd == RND_IDLE
      |=> cnt_val[0] == $past(cnt_val[0]);
  endproperty
  a_frozen: assert property (p_frozen)
    else $error("seconds moved while frozen");

  property p_run_sync;
    @(posedge clk) disable iff (!nrst)
      tick32 |=> running == $past(st_reg.ctrl.run);
  endproperty
  a_run_sync: assert property (p_run_sync)
    else $error("running flag not resynced");

  property p_hour12;
    @(posedge clk) disable iff (!nrst)
      reg_rd && reg_addr == 8'h02 && st_reg.ctrl.hour_12_mode
      |=> reg_rdata[6] == 1'b0 && reg_rdata[5:0] != 6'h00;
  endproperty
  a_hour12: assert property (p_hour12)
    else $error("12-hour read out of range");

  property p_alarm;
    @(posedge clk) disable iff (!nrst)
      alarm_event |-> $past(alarm_irq_enable) && $past(st_reg.day_rolled);
  endproperty
  a_alarm: assert property (p_alarm)
    else $error("alarm event without cause");

  c_snapshot: cover property (@(posedge clk) ctrl_wr && reg_wdata[6]);
  c_round: cover property (@(posedge clk) rnd_go && rnd_bump);
  c_alarm: cover property (@(posedge clk) alarm_event);
  c_comp: cover property (@(posedge clk) sec_tick && hour_due);
endmodule : rtc_alarm_and_control

// file: hw/rtc_ctrl_consts.svh
`ifndef RTC_CTRL_CONSTS_SVH
`define RTC_CTRL_CONSTS_SVH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define OFS_SECONDS      8'h00
`define OFS_HOURS        8'h02
`define OFS_WEEKS        8'h06
`define OFS_ALARM_DAY    8'h0B
`define OFS_ALARM_MONTH  8'h0C
`define OFS_ALARM_YEAR   8'h0D
`define OFS_CTRL         8'h10
// ----------------------------------------
// field positions and writable masks
// ----------------------------------------
`define FLD_SEC          0
`define FLD_MIN          1
`define FLD_HOUR         2
`define FLD_DAY          3
`define FLD_MONTH        4
`define FLD_YEAR         5
`define FLD_WEEK         6
`define NUM_FIELDS       7
`define ALARM_DAY_MASK   8'h3F
`define ALARM_MONTH_MASK 8'h1F
`define PM_BIT           7
// ----------------------------------------
// reset values and field limits
// ----------------------------------------
`define ALARM_DAY_RST    8'h01
`define ALARM_MONTH_RST  8'h01
`define ALARM_YEAR_RST   8'h00
`define CTRL_RST         8'h00
`define MAX_SEC          7'h3B
`define MAX_HOUR         7'h17
`define MAX_MONTH        7'h0C
`define MAX_YEAR         7'h63
`define MAX_WEEK         7'h06
`define ROUND_HALF       7'h1E
`define HOURS_HALF       7'h0C
// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_PERIOD_NS    100
`define TICK32_PERIOD_NS 30518
`define TICK32_CYCLES    (`TICK32_PERIOD_NS / `CLK_PERIOD_NS)
`define PRESCALE_TICKS   32768
`endif

// file: hw/rtc_ctrl_pkg.sv
package rtc_ctrl_pkg;
  // control register layout, bit 7 down to bit 0
  typedef struct packed {
    logic read_source_select;
    logic snapshot_request;
    logic counter_load;
    logic test_mode;
    logic hour_12_mode;
    logic auto_comp;
    logic round_request;
    logic run;
  } ctrl_type;

  typedef enum logic [1:0] {
    RND_IDLE = 2'h1,
    RND_BUSY = 2'h2
  } rnd_state_type;

  typedef struct packed {
    logic [6:0] value;
  } cnt_state_type;

  typedef struct packed {
    logic [8:0] count;
    logic       tick;
  } div_state_type;

  typedef struct packed {
    ctrl_type        ctrl;
    logic [7:0]      al_day;
    logic [7:0]      al_month;
    logic [7:0]      al_year;
    logic [6:0][6:0] shadow;
    logic [15:0]     presc;
    logic            run_sync;
    logic            round_seen;
    logic            day_rolled;
    rnd_state_type   rnd;
    logic [7:0]      rdata;
    logic            alarm_evt;
  } main_state_type;
endpackage : rtc_ctrl_pkg

// file: hw/tick_divider.sv
`timescale 1ns/1ns
`include "rtc_ctrl_consts.svh"
// one-cycle enable at the 32-kHz rate
module tick_divider
  import rtc_ctrl_pkg::*;
(
  input  wire logic clk,
  input  wire logic nrst,
  output logic      tick
);
  div_state_type st_reg;
  div_state_type st_next;

  // count up one 32-kHz period
  always_comb begin
    st_next = st_reg;
    st_next.tick = 1'b0;
    if (st_reg.count == 9'(`TICK32_CYCLES - 1)) begin
      st_next.count = 9'h000;
      st_next.tick = 1'b1;
    end else begin
      st_next.count = st_reg.count + 9'h001;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign tick = st_reg.tick;
endmodule : tick_divider

// file: hw/wrap_counter.sv
`timescale 1ns/1ns
// one calendar field, wraps from high back to low
module wrap_counter
  import rtc_ctrl_pkg::*;
#(
  parameter logic [6:0] LOW = 7'h00
) (
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       inc,
  input  wire logic       load,
  input  wire logic [6:0] load_val,
  input  wire logic [6:0] high,
  output logic [6:0]      value,
  output logic            carry
);
  cnt_state_type st_reg;
  cnt_state_type st_next;

  // carry into the next field on wrap
  assign carry = inc && (st_reg.value >= high);

  // load wins over counting
  always_comb begin
    st_next = st_reg;
    if (load) begin
      st_next.value = load_val;
    end else if (inc) begin
      st_next.value = carry ? LOW : st_reg.value + 7'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      st_reg <= '{value: LOW};
    end else begin
      st_reg <= st_next;
    end
  end

  assign value = st_reg.value;
endmodule : wrap_counter

// file: tb/host_model.sv
`timescale 1ns/1ns
// ----------------------------------------
// host side of the register strobe port
// ----------------------------------------
module host_model (
  input  wire logic       clk,
  input  wire logic [7:0] reg_rdata,
  output logic [7:0]      reg_addr,
  output logic [7:0]      reg_wdata,
  output logic            reg_wr,
  output logic            reg_rd
);
  // idle bus values at time zero
  initial begin
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
  end

  // one write: strobe held over one taking edge, then dropped
  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    @(posedge clk);
    reg_addr  <= addr;
    reg_wdata <= data;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
    reg_wdata <= ~data; // released data no longer shows the last value
  endtask : wr

  // one read: data taken once the answer has landed
  task automatic rd(input logic [7:0] addr, output logic [7:0] data);
    @(posedge clk);
    reg_addr <= addr;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    @(posedge clk);
    data = reg_rdata;
  endtask : rd

  // control read preceded by a discarded read to refresh the round bit
  task automatic rd_ctrl(output logic [7:0] data);
    logic [7:0] dummy;
    rd(8'h10, dummy);
    rd(8'h10, data);
  endtask : rd_ctrl
endmodule : host_model

// file: tb/test_rtc_alarm_and_control.sv
`timescale 1ns/1ns
`include "rtc_ctrl_consts.svh"
module test_rtc_alarm_and_control;
  import rtc_ctrl_pkg::*;
  localparam int TICKS = 4;
  localparam int LIMIT = 30000;

  logic        clk;
  logic        nrst;
  logic [7:0]  reg_addr;
  logic [7:0]  reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [15:0] comp_value;
  logic        alarm_irq_enable;
  logic [7:0]  reg_rdata;
  logic        alarm_event;
  logic        running;
  logic [7:0]  v;
  int          err_total;
  int          checks_done;
  int          cycles;
  int          alarms;

  // ----------------------------------------
  // clock, design and host
  // ----------------------------------------
  initial clk = 1'b0;
  always #50 clk = ~clk;

  rtc_alarm_and_control #(.PRESCALE_TICKS(TICKS)) dut_u (
    .clk              (clk),
    .nrst             (nrst),
    .reg_addr         (reg_addr),
    .reg_wdata        (reg_wdata),
    .reg_wr           (reg_wr),
    .reg_rd           (reg_rd),
    .comp_value       (comp_value),
    .alarm_irq_enable (alarm_irq_enable),
    .reg_rdata        (reg_rdata),
    .alarm_event      (alarm_event),
    .running          (running)
  );

  host_model host_u (
    .clk       (clk),
    .reg_rdata (reg_rdata),
    .reg_addr  (reg_addr),
    .reg_wdata (reg_wdata),
    .reg_wr    (reg_wr),
    .reg_rd    (reg_rd)
  );

  // ----------------------------------------
  // comparison, alarm pulse count, timeout
  // ----------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %0t ns: read %h, expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic rcheck(input logic [7:0] addr, input logic [7:0] exp);
    logic [7:0] d;
    host_u.rd(addr, d);
    check(d, exp);
  endtask : rcheck

  task automatic print_verdict;
    $display("checks_done=%0d err_total=%0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : print_verdict

  // counts alarm pulses and cuts a hang short
  always @(posedge clk) begin
    cycles++;
    if (nrst && alarm_event === 1'b1) alarms++;
    if (cycles == LIMIT) begin
      err_total++;
      $display("[FAIL] %0t ns: cycle limit reached", $time);
      print_verdict();
    end
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    nrst             = 1'b0;
    comp_value       = 16'h0000;
    alarm_irq_enable = 1'b0;
    err_total        = 0;
    checks_done      = 0;
    cycles           = 0;
    alarms           = 0;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    // reset values
    rcheck(`OFS_ALARM_DAY, `ALARM_DAY_RST);
    rcheck(`OFS_ALARM_MONTH, `ALARM_MONTH_RST);
    rcheck(`OFS_ALARM_YEAR, `ALARM_YEAR_RST);
    host_u.rd_ctrl(v);
    check(v, `CTRL_RST);
    check({7'h00, running}, 8'h00);
    // alarm date fields, reserved bits, unmapped offset
    host_u.wr(`OFS_ALARM_DAY, 8'hFF);
    host_u.wr(`OFS_ALARM_MONTH, 8'hFF);
    host_u.wr(`OFS_ALARM_YEAR, 8'h99);
    host_u.wr(8'h20, 8'h5A);
    rcheck(`OFS_ALARM_DAY, 8'h3F);
    rcheck(`OFS_ALARM_MONTH, 8'h1F);
    rcheck(`OFS_ALARM_YEAR, 8'h99);
    rcheck(8'h20, 8'h00);
    // hour format: midnight in both formats, then counter load bit
    host_u.wr(`OFS_CTRL, 8'h08);
    host_u.rd_ctrl(v);
    check(v, 8'h08);
    rcheck(`OFS_HOURS, 8'h12);
    host_u.wr(`OFS_CTRL, 8'h00);
    rcheck(`OFS_HOURS, 8'h00);
    comp_value <= 16'h0002;
    host_u.wr(`OFS_CTRL, 8'h20);
    host_u.rd_ctrl(v);
    check(v, 8'h20);
    host_u.wr(`OFS_CTRL, 8'h00);
    // snapshot and read source
    host_u.wr(`OFS_SECONDS, 8'h15);
    host_u.wr(`OFS_CTRL, 8'h40);
    host_u.wr(`OFS_SECONDS, 8'h45);
    host_u.wr(`OFS_CTRL, 8'hC0);
    rcheck(`OFS_SECONDS, 8'h15);
    host_u.wr(`OFS_CTRL, 8'h80);
    host_u.wr(`OFS_CTRL, 8'hC0);
    rcheck(`OFS_SECONDS, 8'h45);
    host_u.wr(`OFS_CTRL, 8'h00);
    rcheck(`OFS_SECONDS, 8'h45);
    // rounding up from 45 s, then down from 20 s
    host_u.wr(`OFS_CTRL, 8'h02);
    repeat (5) @(posedge clk);
    host_u.rd_ctrl(v);
    check(v, 8'h00);
    rcheck(`OFS_SECONDS, 8'h00);
    rcheck(8'h01, 8'h01);
    host_u.wr(`OFS_SECONDS, 8'h20);
    host_u.wr(`OFS_CTRL, 8'h02);
    host_u.rd_ctrl(v);
    check(v, 8'h02);
    host_u.rd_ctrl(v);
    check(v, 8'h00);
    rcheck(`OFS_SECONDS, 8'h00);
    rcheck(8'h01, 8'h01);
    // alarm on day rollover to 02 Jan 00
    host_u.wr(`OFS_ALARM_DAY, 8'h02);
    host_u.wr(`OFS_ALARM_MONTH, 8'h01);
    host_u.wr(`OFS_ALARM_YEAR, 8'h00);
    host_u.wr(`OFS_SECONDS, 8'h59);
    host_u.wr(8'h01, 8'h59);
    host_u.wr(`OFS_HOURS, 8'h23);
    alarm_irq_enable <= 1'b1;
    host_u.wr(`OFS_CTRL, 8'h01);
    repeat (700) @(posedge clk);
    check({7'h00, running}, 8'h01);
    repeat (3000) @(posedge clk);
    host_u.wr(`OFS_CTRL, 8'h00);
    repeat (700) @(posedge clk);
    check({7'h00, running}, 8'h00);
    rcheck(8'h03, 8'h02);
    rcheck(`OFS_HOURS, 8'h00);
    check(alarms[7:0], 8'h01);
    // frozen counters stay put
    host_u.rd(`OFS_SECONDS, v);
    repeat (2500) @(posedge clk);
    rcheck(`OFS_SECONDS, v);
    // mid-run full reset brings the registers back to defaults
    nrst <= 1'b0;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    rcheck(`OFS_ALARM_DAY, `ALARM_DAY_RST);
    host_u.rd_ctrl(v);
    check(v, `CTRL_RST);
    print_verdict();
  end
endmodule : test_rtc_alarm_and_control
